// ==== hw/csel_pkg.sv ====
// Constants shared by the configuration and reference select block
package csel_pkg;
	// Clock and timing
	localparam int CLK_PERIOD_PS  = 8_000;
	localparam int LIVE_DELAY_MS  = 10;
	localparam int LOAD_HOLD_MS   = 1;
	localparam int DEBOUNCE_NS    = 1_000;
	localparam int GUARD_NS       = 64;
	// Divide first: the plain product would overflow a 32-bit int
	localparam int LIVE_CYC_DEF   = LIVE_DELAY_MS * (1_000_000_000 / CLK_PERIOD_PS);
	localparam int HOLD_CYC_DEF   = LOAD_HOLD_MS * 1_000_000_000 / CLK_PERIOD_PS;
	localparam int DEBOUNCE_CYC   = (DEBOUNCE_NS * 1_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int GUARD_CYC      = (GUARD_NS * 1_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SETTLE_CYC     = DEBOUNCE_CYC + 4;
	localparam int LIVE_W         = 21;
	localparam int HOLD_W         = 17;
	localparam int GUARD_W        = 4;
	localparam int DEB_W          = 8;

	// Serial register addresses and fields
	localparam logic [7:0] ADDR_TRIM      = 8'h12;
	localparam logic [7:0] ADDR_REFCTL    = 8'h13;
	localparam logic [7:0] ADDR_SPREAD    = 8'h14;
	localparam int         PRIM_BIT       = 1;
	localparam int         SM_LSB         = 6;
	localparam int         SM_MANUAL_BIT  = 1;
	localparam int         TRIM_LSB       = 0;
	localparam int         SPR_EN_BIT     = 0;
	localparam int         SPR_DOWN_BIT   = 1;
	localparam int         SPR_AMT_LSB    = 2;

	// Reset values
	localparam logic       PRIM_RST       = 1'b0;
	localparam logic [1:0] SM_RST         = 2'h0;
	localparam logic [5:0] TRIM_RST       = 6'h00;
	localparam logic [4:0] SPR_AMT_RST    = 5'h00;
	localparam logic [1:0] CFG_DEFAULT    = 2'h0;

	// Spread amount in 0.25 percent steps
	localparam logic [4:0] SPR_CTR_MIN    = 5'h01;
	localparam logic [4:0] SPR_CTR_MAX    = 5'h0A;
	localparam logic [4:0] SPR_DOWN_MIN   = 5'h02;
	localparam logic [4:0] SPR_DOWN_MAX   = 5'h14;

	typedef enum logic [1:0] {ST_POR, ST_HOLD, ST_RUN} csel_state_t;
	typedef enum logic {SW_IDLE, SW_GUARD} csel_sw_t;
endpackage

// ==== hw/csel_debounce.sv ====
// Synchroniser and debouncer for one board select pin
`timescale 1ns/1ps
module csel_debounce #(
	parameter int CYC = 125
) (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic pin_raw,
	output logic      level_ff
);
	import csel_pkg::*;

	logic             s1_ff;
	logic             s2_ff;
	logic [DEB_W-1:0] cnt_ff;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
		end else begin
			s1_ff <= pin_raw;
			s2_ff <= s1_ff;
		end
	end

	// Floating pins read low, so the idle level is 0
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff   <= '0;
			level_ff <= 1'b0;
		end else if (s2_ff == level_ff) begin
			cnt_ff <= '0;
		end else if (cnt_ff == DEB_W'(CYC - 1)) begin
			cnt_ff   <= '0;
			level_ff <= s2_ff;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	chk_debounce_stable: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$changed(level_ff) |-> $past(s2_ff, 2) == level_ff && $past(s2_ff) == level_ff)
		else $error("debounced level changed without a stable input");
endmodule // csel_debounce

// ==== hw/csel_top.sv ====
// Configuration select and reference input select for the clock generator
`timescale 1ns/1ps
module csel_top #(
	parameter int LIVE_CYC = csel_pkg::LIVE_CYC_DEF,
	parameter int HOLD_CYC = csel_pkg::HOLD_CYC_DEF
) (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic strap_serial_select_pin,
	input  wire logic config_select_hi,
	input  wire logic config_select_lo,
	input  wire logic stored_default_flag,
	input  wire logic input_select_pin,
	input  wire logic serial_wr_en,
	input  wire logic [7:0] serial_wr_addr,
	input  wire logic [7:0] serial_wr_data,
	input  wire logic serial_cfg_load,
	input  wire logic [1:0] serial_cfg_index,
	output logic      serial_enable_ff,
	output logic [1:0] cfg_index_ff,
	output logic      cfg_load_ff,
	output logic      defaults_load_ff,
	output logic      load_busy_ff,
	output logic      primary_source_bit_ff,
	output logic [1:0] switchover_mode_field_ff,
	output logic [5:0] crystal_load_trim_code_ff,
	output logic      ref_active_diff_ff,
	output logic      ref_gate_xtal_ff,
	output logic      ref_gate_diff_ff,
	output logic      spread_enable_ff,
	output logic      spread_down_ff,
	output logic [4:0] spread_amount_ff
);
	import csel_pkg::*;

	logic              strap_db;
	logic              sel_hi_db;
	logic              sel_lo_db;
	logic              in_sel_db;
	logic [LIVE_W-1:0] op_cnt_ff;
	logic              live_ok_ff;
	logic [HOLD_W-1:0] hold_cnt_ff;
	csel_state_t       state_ff;
	csel_sw_t          sw_ff;
	logic [GUARD_W-1:0] guard_cnt_ff;
	logic              tgt_diff_ff;
	logic              manual_mode;
	logic              want_diff;
	logic              por_done;
	logic              wr_ok;
	logic [1:0]        pins;
	logic [4:0]        nxt_amt;
	logic              nxt_down;

	csel_debounce #(.CYC(DEBOUNCE_CYC)) u_db_strap (.clk_sys(clk_sys), .rst_b(rst_b),
		.pin_raw(strap_serial_select_pin), .level_ff(strap_db));
	csel_debounce #(.CYC(DEBOUNCE_CYC)) u_db_hi (.clk_sys(clk_sys), .rst_b(rst_b),
		.pin_raw(config_select_hi), .level_ff(sel_hi_db));
	csel_debounce #(.CYC(DEBOUNCE_CYC)) u_db_lo (.clk_sys(clk_sys), .rst_b(rst_b),
		.pin_raw(config_select_lo), .level_ff(sel_lo_db));
	csel_debounce #(.CYC(DEBOUNCE_CYC)) u_db_in (.clk_sys(clk_sys), .rst_b(rst_b),
		.pin_raw(input_select_pin), .level_ff(in_sel_db));

	assign pins        = {sel_hi_db, sel_lo_db};
	assign por_done    = (op_cnt_ff >= LIVE_W'(SETTLE_CYC));
	assign wr_ok       = serial_wr_en && serial_enable_ff;
	assign manual_mode = !switchover_mode_field_ff[SM_MANUAL_BIT];
	assign want_diff   = in_sel_db ^ primary_source_bit_ff;

	// Time since reset release; saturates at the live-change threshold
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			op_cnt_ff  <= '0;
			live_ok_ff <= 1'b0;
		end else if (op_cnt_ff == LIVE_W'(LIVE_CYC - 1)) begin
			live_ok_ff <= 1'b1;
		end else begin
			op_cnt_ff <= op_cnt_ff + 1'b1;
		end
	end

	// Power-up latch, configuration loads and the post-load hold
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_ff         <= ST_POR;
			serial_enable_ff <= 1'b0;
			cfg_index_ff     <= CFG_DEFAULT;
			cfg_load_ff      <= 1'b0;
			defaults_load_ff <= 1'b0;
			load_busy_ff     <= 1'b1;
			hold_cnt_ff      <= '0;
		end else begin
			cfg_load_ff      <= 1'b0;
			defaults_load_ff <= 1'b0;
			unique case (state_ff)
				ST_POR: begin
					// Wait until the debouncers have seen the settled pin levels
					if (por_done) begin
						serial_enable_ff <= !strap_db;
						hold_cnt_ff      <= HOLD_W'(HOLD_CYC - 1);
						state_ff         <= ST_HOLD;
						if (strap_db) begin
							cfg_index_ff <= pins;
							cfg_load_ff  <= 1'b1;
						end else if (stored_default_flag) begin
							defaults_load_ff <= 1'b1;
						end else begin
							cfg_index_ff <= CFG_DEFAULT;
							cfg_load_ff  <= 1'b1;
						end
					end
				end
				ST_HOLD: begin
					// New settings need time to load; no pin change or serial load is taken meanwhile, though register writes still land
					if (hold_cnt_ff == '0) begin
						load_busy_ff <= 1'b0;
						state_ff     <= ST_RUN;
					end else begin
						hold_cnt_ff <= hold_cnt_ff - 1'b1;
					end
				end
				ST_RUN: begin
					if (!serial_enable_ff && !stored_default_flag && live_ok_ff
						&& pins != cfg_index_ff) begin
						cfg_index_ff <= pins;
						cfg_load_ff  <= 1'b1;
						load_busy_ff <= 1'b1;
						hold_cnt_ff  <= HOLD_W'(HOLD_CYC - 1);
						state_ff     <= ST_HOLD;
					end else if (serial_enable_ff && serial_cfg_load) begin
						cfg_index_ff <= serial_cfg_index;
						cfg_load_ff  <= 1'b1;
						load_busy_ff <= 1'b1;
						hold_cnt_ff  <= HOLD_W'(HOLD_CYC - 1);
						state_ff     <= ST_HOLD;
					end
				end
			endcase
		end
	end

	// Serial-written control fields; writes only land while serial access is on
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			primary_source_bit_ff    <= PRIM_RST;
			switchover_mode_field_ff <= SM_RST;
		end else if (wr_ok && serial_wr_addr == ADDR_REFCTL) begin
			primary_source_bit_ff    <= serial_wr_data[PRIM_BIT];
			switchover_mode_field_ff <= serial_wr_data[SM_LSB +: 2];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			crystal_load_trim_code_ff <= TRIM_RST;
		end else if (wr_ok && serial_wr_addr == ADDR_TRIM) begin
			crystal_load_trim_code_ff <= serial_wr_data[TRIM_LSB +: 6];
		end
	end

	// Spread amount is clamped to what the divider modulation supports
	always_comb begin
		nxt_down = serial_wr_data[SPR_DOWN_BIT];
		nxt_amt  = serial_wr_data[SPR_AMT_LSB +: 5];
		if (nxt_down) begin
			if (nxt_amt < SPR_DOWN_MIN) nxt_amt = SPR_DOWN_MIN;
			if (nxt_amt > SPR_DOWN_MAX) nxt_amt = SPR_DOWN_MAX;
		end else begin
			if (nxt_amt < SPR_CTR_MIN) nxt_amt = SPR_CTR_MIN;
			if (nxt_amt > SPR_CTR_MAX) nxt_amt = SPR_CTR_MAX;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			spread_enable_ff <= 1'b0;
			spread_down_ff   <= 1'b0;
			spread_amount_ff <= SPR_AMT_RST;
		end else if (wr_ok && serial_wr_addr == ADDR_SPREAD) begin
			spread_enable_ff <= serial_wr_data[SPR_EN_BIT];
			spread_down_ff   <= nxt_down;
			spread_amount_ff <= nxt_amt;
		end
	end

	// Break-before-make: both gates close for a guard time before the new one opens
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sw_ff              <= SW_IDLE;
			guard_cnt_ff       <= '0;
			tgt_diff_ff        <= 1'b0;
			ref_active_diff_ff <= 1'b0;
			ref_gate_xtal_ff   <= 1'b1;
			ref_gate_diff_ff   <= 1'b0;
		end else begin
			unique case (sw_ff)
				SW_IDLE: begin
					if (manual_mode && want_diff != ref_active_diff_ff) begin
						tgt_diff_ff      <= want_diff;
						ref_gate_xtal_ff <= 1'b0;
						ref_gate_diff_ff <= 1'b0;
						guard_cnt_ff     <= GUARD_W'(GUARD_CYC - 1);
						sw_ff            <= SW_GUARD;
					end
				end
				SW_GUARD: begin
					if (guard_cnt_ff == '0) begin
						ref_active_diff_ff <= tgt_diff_ff;
						ref_gate_xtal_ff   <= !tgt_diff_ff;
						ref_gate_diff_ff   <= tgt_diff_ff;
						sw_ff              <= SW_IDLE;
					end else begin
						guard_cnt_ff <= guard_cnt_ff - 1'b1;
					end
				end
			endcase
		end
	end

	chk_por_pin_index: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state_ff == ST_POR && por_done && strap_db)
		|=> cfg_load_ff && cfg_index_ff == $past(pins) && !serial_enable_ff)
		else $error("power-up load did not follow the select pins");

	chk_por_serial_mode: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state_ff == ST_POR && por_done && !strap_db)
		|=> serial_enable_ff && (defaults_load_ff == $past(stored_default_flag))
			&& (cfg_load_ff == !$past(stored_default_flag)))
		else $error("strap-low power-up load wrong");

	chk_live_too_early: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state_ff == ST_RUN && (!live_ok_ff || stored_default_flag) && !serial_enable_ff)
		|=> !cfg_load_ff)
		else $error("select pin change honoured too early or with flag set");

	chk_load_hold_time: assert property (@(posedge clk_sys) disable iff (!rst_b)
		cfg_load_ff |-> load_busy_ff ##1 load_busy_ff [*8])
		else $error("busy not held after configuration load");

	chk_serial_no_pins: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state_ff == ST_RUN && serial_enable_ff && !serial_cfg_load) |=> !cfg_load_ff)
		else $error("pins loaded a configuration in serial mode");

	chk_prim_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(serial_enable_ff && serial_wr_en && serial_wr_addr == 8'h13)
		|=> primary_source_bit_ff == $past(serial_wr_data[1]))
		else $error("primary source bit not written");

	chk_gate_exclusive: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$changed(ref_active_diff_ff)
		|-> $past(!ref_gate_xtal_ff && !ref_gate_diff_ff, 1)
			&& $past(!ref_gate_xtal_ff && !ref_gate_diff_ff, 2))
		else $error("reference changed without a closed guard gap");

	chk_ref_choice: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(sw_ff == SW_IDLE && manual_mode && want_diff != ref_active_diff_ff)
		|-> ##9 (ref_active_diff_ff == $past(want_diff, 9)))
		else $error("reference select did not follow pin and primary bit");

	chk_trim_locked: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!serial_enable_ff |=> $stable(crystal_load_trim_code_ff))
		else $error("trim code changed without serial access");

	chk_spread_limit: assert property (@(posedge clk_sys) disable iff (!rst_b)
		spread_enable_ff |-> (spread_down_ff ? (spread_amount_ff >= 5'h02
			&& spread_amount_ff <= 5'h14) : (spread_amount_ff >= 5'h01
			&& spread_amount_ff <= 5'h0A)))
		else $error("spread amount out of range");
endmodule // csel_top

// ==== bench/csel_board.sv ====
// Board model: strap, select pins and a serial host writing registers
`timescale 1ns/1ps
module csel_board (
	input  wire logic       clk_sys,
	output logic            strap_serial_select_pin,
	output logic            config_select_hi,
	output logic            config_select_lo,
	output logic            stored_default_flag,
	output logic            input_select_pin,
	output logic            serial_wr_en,
	output logic [7:0]      serial_wr_addr,
	output logic [7:0]      serial_wr_data,
	output logic            serial_cfg_load,
	output logic [1:0]      serial_cfg_index
);
	initial begin
		{strap_serial_select_pin, config_select_hi, config_select_lo} = 3'h0;
		{stored_default_flag, input_select_pin, serial_wr_en, serial_cfg_load} = 4'h0;
		{serial_wr_addr, serial_wr_data, serial_cfg_index} = 18'h0_0000;
	end
	// Pins driven to a solid level, never floating
	task automatic boot(input logic s, input logic f, input logic [1:0] i);
		@(negedge clk_sys);
		strap_serial_select_pin = s;
		stored_default_flag = f;
		{config_select_hi, config_select_lo} = i;
	endtask
	// Only one select pin moves per call
	task automatic flip(input logic h);
		@(negedge clk_sys);
		if (h) config_select_hi = ~config_select_hi;
		else config_select_lo = ~config_select_lo;
	endtask
	task automatic refsel(input logic v);
		@(negedge clk_sys);
		input_select_pin = v;
	endtask
	// Released lines show the inverse so stale values cannot pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		{serial_wr_en, serial_wr_addr, serial_wr_data} = {1'b1, a, d};
		@(negedge clk_sys);
		{serial_wr_en, serial_wr_addr, serial_wr_data} = {1'b0, ~a, ~d};
	endtask
	task automatic load(input logic [1:0] i);
		@(negedge clk_sys);
		{serial_cfg_load, serial_cfg_index} = {1'b1, i};
		@(negedge clk_sys);
		{serial_cfg_load, serial_cfg_index} = {1'b0, ~i};
	endtask
endmodule // csel_board

// ==== bench/csel_top_tb.sv ====
// Self-checking bench for the configuration and reference select block
`timescale 1ns/1ps
module csel_top_tb;
	import csel_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic strap_serial_select_pin, config_select_hi, config_select_lo, stored_default_flag;
	logic input_select_pin, serial_wr_en, serial_cfg_load, serial_enable_ff, cfg_load_ff;
	logic defaults_load_ff, load_busy_ff, primary_source_bit_ff, ref_active_diff_ff;
	logic ref_gate_xtal_ff, ref_gate_diff_ff, spread_enable_ff, spread_down_ff;
	logic [7:0] serial_wr_addr, serial_wr_data;
	logic [1:0] serial_cfg_index, cfg_index_ff, switchover_mode_field_ff, got, idx;
	logic [5:0] crystal_load_trim_code_ff, t;
	logic [4:0] spread_amount_ff;
	logic       p, s;
	int         fail_count = 0;
	int         comparisons = 0;
	int         overlap = 0;

	always #4 clk_sys = ~clk_sys;

	csel_top #(.LIVE_CYC(300), .HOLD_CYC(20)) dut (.clk_sys, .rst_b,
		.strap_serial_select_pin, .config_select_hi, .config_select_lo,
		.stored_default_flag, .input_select_pin, .serial_wr_en, .serial_wr_addr,
		.serial_wr_data, .serial_cfg_load, .serial_cfg_index, .serial_enable_ff,
		.cfg_index_ff, .cfg_load_ff, .defaults_load_ff, .load_busy_ff,
		.primary_source_bit_ff, .switchover_mode_field_ff, .crystal_load_trim_code_ff,
		.ref_active_diff_ff, .ref_gate_xtal_ff, .ref_gate_diff_ff, .spread_enable_ff,
		.spread_down_ff, .spread_amount_ff);
	csel_board board (.clk_sys, .strap_serial_select_pin, .config_select_hi,
		.config_select_lo, .stored_default_flag, .input_select_pin, .serial_wr_en,
		.serial_wr_addr, .serial_wr_data, .serial_cfg_load, .serial_cfg_index);

	always @(posedge clk_sys) begin
		if (rst_b && ref_gate_xtal_ff === 1'b1 && ref_gate_diff_ff === 1'b1) overlap++;
	end

	function automatic logic exp_diff(input logic sel, input logic prim);
		return sel ^ prim;
	endfunction
	function automatic logic [1:0] exp_idx(input logic strap, input logic [1:0] pins);
		return strap ? pins : CFG_DEFAULT;
	endfunction

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic do_reset(input logic st, input logic f, input logic [1:0] i);
		@(negedge clk_sys);
		rst_b = 1'b0;
		board.boot(st, f, i);
		repeat (8) @(negedge clk_sys);
		rst_b = 1'b1;
	endtask
	// Returns {defaults pulse, config pulse} of the first load seen
	task automatic wait_pulse(input int n);
		got = 2'b00;
		repeat (n) begin
			@(posedge clk_sys);
			#1;
			if (cfg_load_ff === 1'b1 || defaults_load_ff === 1'b1) begin
				got = {defaults_load_ff, cfg_load_ff};
				break;
			end
		end
	endtask
	task automatic ref_check(input logic e);
		repeat (200) @(posedge clk_sys);
		#1;
		chk("ref_active_diff", {7'h0, e}, {7'h0, ref_active_diff_ff});
		chk("ref_gates", {6'h0, e, ~e}, {6'h0, ref_gate_diff_ff, ref_gate_xtal_ff});
	endtask
	task automatic summarize();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#(8 * 20_000);
		fail_count++;
		summarize();
	end

	initial begin
		void'($urandom(32'h4c6f9e66));
		for (int k = 0; k < 4; k++) begin
			do_reset(1'b1, 1'b0, k[1:0]);
			wait_pulse(300);
			chk("boot_load", 8'h01, {6'h0, got});
			chk("cfg_index", {6'h0, exp_idx(1'b1, k[1:0])}, {6'h0, cfg_index_ff});
			chk("serial_enable", 8'h00, {7'h0, serial_enable_ff});
			$display("test boot_pins %0d done", k);
		end
		// Live changes, one pin at a time, once the start-up wait is over
		repeat (300) @(posedge clk_sys);
		for (int k = 0; k < 3; k++) begin
			s = 1'($urandom);
			idx = cfg_index_ff ^ {s, ~s};
			board.flip(s);
			wait_pulse(300);
			chk("live_load", 8'h01, {6'h0, got});
			chk("live_index", {6'h0, idx}, {6'h0, cfg_index_ff});
			chk("live_busy", 8'h01, {7'h0, load_busy_ff});
			repeat (40) @(posedge clk_sys);
		end
		board.wr(ADDR_REFCTL, 8'h02);
		s = 1'($urandom);
		board.refsel(s);
		ref_check(exp_diff(s, 1'b0));
		chk("prim_in_pin_mode", 8'h00, {7'h0, primary_source_bit_ff});
		$display("test live_pins done");
		do_reset(1'b1, 1'b1, 2'h2);
		wait_pulse(300);
		repeat (300) @(posedge clk_sys);
		board.flip(1'b0);
		wait_pulse(300);
		chk("flag_blocks_live", 8'h00, {6'h0, got});
		$display("test flag_block done");
		do_reset(1'b0, 1'b1, 2'h1);
		wait_pulse(300);
		chk("defaults_load", 8'h02, {6'h0, got});
		chk("serial_enable", 8'h01, {7'h0, serial_enable_ff});
		repeat (300) @(posedge clk_sys);
		board.flip(1'b1);
		wait_pulse(300);
		chk("pins_ignored", 8'h00, {6'h0, got});
		idx = 2'($urandom);
		board.load(idx);
		// The load pulse stands from the taking edge to the next one; look at it now
		got = {defaults_load_ff, cfg_load_ff};
		chk("serial_load", {4'h0, idx, 2'h1}, {4'h0, cfg_index_ff, got});
		t = 6'($urandom);
		p = 1'($urandom);
		board.wr(ADDR_TRIM, {2'h0, t});
		board.wr(ADDR_REFCTL, {6'h0, p, 1'b0});
		board.wr(8'h55, 8'hFF);
		#1;
		chk("trim", {2'h0, t}, {2'h0, crystal_load_trim_code_ff});
		chk("prim", {7'h0, p}, {7'h0, primary_source_bit_ff});
		chk("sm_manual", 8'h00, {6'h0, switchover_mode_field_ff});
		s = ~input_select_pin;
		board.refsel(s);
		ref_check(exp_diff(s, p));
		board.wr(ADDR_SPREAD, 8'h13);
		#1;
		chk("spread", 8'h13, {1'b0, spread_amount_ff, spread_down_ff, spread_enable_ff});
		board.wr(ADDR_SPREAD, 8'h7D);
		#1;
		chk("spread_clamp", {1'b0, SPR_CTR_MAX, 2'b01},
			{1'b0, spread_amount_ff, spread_down_ff, spread_enable_ff});
		board.wr(ADDR_REFCTL, {2'h2, 4'h0, p, 1'b0});
		board.refsel(~s);
		ref_check(exp_diff(s, p));
		$display("test serial_mode done");
		do_reset(1'b0, 1'b0, 2'h3);
		wait_pulse(300);
		chk("serial_cfg0", {6'h1, exp_idx(1'b0, 2'h3)}, {5'h0, got[0], cfg_index_ff});
		chk("gate_overlap", 8'h00, overlap[7:0]);
		$display("test serial_default done");
		summarize();
	end
endmodule // csel_top_tb
